// *** logic/adcc_pkg.sv ***
// Constants, register map and types for the calibration/averaging control
// How it works
// - Start bit launches calibration, self-clears when done
// - Starting calibration aborts any running conversion
// - Trigger select, control/offset/gain/claim register write, stop fail calibration
// - Fail flag clears only by writing one
// - Continuous enable repeats conversions or averaged sets
// - Mean enable switches averaging on or off
// - Mean count selects four, eight, sixteen, thirty-two
// - Subtract left-justified signed offset from each conversion
// - Corrected result clamps to the mode limits
// - Plus gain scales plus input or whole conversion
// - Minus gain corrects minus input, differential only
// - Calibration end loads seven plus-side trim values
// - Calibration end loads seven minus-side trim values
// - First claim register: channels 0 to 7
// - Second claim register: channels 8 to 15
// - Claim bit one removes port control of pin
// - Claimed pin: output off, input zero, pullup off
package adcc_pkg;

  // Word indices; byte address is four times the index
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_OFS_HI  = 5'h01;
  localparam logic [4:0] REG_OFS_LO  = 5'h02;
  localparam logic [4:0] REG_PG_HI   = 5'h03;
  localparam logic [4:0] REG_PG_LO   = 5'h04;
  localparam logic [4:0] REG_MG_HI   = 5'h05;
  localparam logic [4:0] REG_MG_LO   = 5'h06;
  localparam logic [4:0] REG_CLAIM_1 = 5'h07;
  localparam logic [4:0] REG_CLAIM_2 = 5'h08;
  localparam logic [4:0] REG_CFG     = 5'h09;
  localparam logic [4:0] REG_STAT    = 5'h0a;
  localparam logic [4:0] REG_MASK    = 5'h0b;
  localparam logic [4:0] REG_RESULT  = 5'h0c;
  localparam logic [4:0] REG_TRIMP_L = 5'h0d;
  localparam logic [4:0] REG_TRIMP_H = 5'h0e;
  localparam logic [4:0] REG_TRIMM_L = 5'h0f;
  localparam logic [4:0] REG_TRIMM_H = 5'h10;

  // Control register fields
  localparam int CTRL_CAL_BIT  = 7;
  localparam int CTRL_SELFTRIM_FAIL_FLAG_BIT = 6;
  localparam int CTRL_CONTINUOUS_RUN_ENABLE_BIT = 3;
  localparam int CTRL_MEAN_ENABLE_BIT = 2;
  localparam int CTRL_MEAN_COUNT_SELECT_LSB = 0;
  // Configuration register fields
  localparam int CFG_TRG_BIT   = 0;
  localparam int CFG_DIFF_BIT  = 1;
  localparam int CFG_START_BIT = 2;
  // Interrupt status and mask fields
  localparam int IRQ_READY   = 0;
  localparam int IRQ_CALDONE = 1;
  localparam int IRQ_CALFAIL = 2;

  // Reset values
  localparam logic [15:0] GAIN_RESET  = 16'h8000;
  localparam logic [15:0] OFS_RESET   = 16'h0000;
  localparam logic [15:0] CLAIM_RESET = 16'h0000;

  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CAL_TIME_NS   = 5000;
  localparam int CAL_CYCLES    = (CAL_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int CAL_CNT_W     = 11;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_CAL  = 2'b10
  } adcc_state_t;

endpackage

// *** logic/adcc_calib_avg.sv ***
// Calibration, continuous conversion and averaging control with Avalon slave
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module adcc_calib_avg (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        convDone,
  input  wire logic [15:0] rawPlus,
  input  wire logic [15:0] rawMinus,
  input  wire logic [5:0]  calCodePlus,
  input  wire logic [5:0]  calCodeMinus,
  input  wire logic        hwTrigger,
  input  wire logic        stopMode,
  output logic             convStart,
  output logic             convAbort,
  output logic             calBusy,
  output logic             irq,
  input  wire logic [15:0] portOe,
  input  wire logic [15:0] portPullEn,
  input  wire logic [15:0] padIn,
  output logic      [15:0] padOe,
  output logic      [15:0] padPullEn,
  output logic      [15:0] portIn,
  output logic      [15:0] pinClaim
);
  import adcc_pkg::*;

  typedef struct packed {
    adcc_state_t          st;
    logic [CAL_CNT_W-1:0] calCnt;
    logic                 selftrim_fail_flag;
    logic                 continuous_run_enable;
    logic                 mean_enable;
    logic [1:0]           mean_count_select;
    logic                 trgSel;
    logic                 diffMode;
    logic [15:0]          ofs;
    logic [15:0]          pg;
    logic [15:0]          mg;
    logic [15:0]          claim;
    logic [51:0]          trimP;
    logic [51:0]          trimM;
    logic [2:0]           irqStat;
    logic [2:0]           irqMask;
    logic [15:0]          result;
    logic [21:0]          acc;
    logic [5:0]           avgCnt;
    logic                 convStart;
    logic                 convAbort;
    logic                 hw1;
    logic                 hw2;
    logic                 hw3;
    logic                 stop1;
    logic                 stop2;
    logic [15:0]          pad1;
    logic [15:0]          pad2;
    logic [15:0]          portIn;
    logic [15:0]          padOe;
    logic [15:0]          padPull;
    logic                 ack;
    logic [31:0]          rdata;
  } adcc_regs_t;

  adcc_regs_t s_q;
  adcc_regs_t s_d;

  // Gain, offset and clamp for one conversion
  function automatic logic [15:0] correct(
    input logic [15:0] p,
    input logic [15:0] m,
    input logic [15:0] pgain,
    input logic [15:0] mgain,
    input logic [15:0] ofs,
    input logic        diff
  );
    logic [31:0]        pp;
    logic [31:0]        mm;
    logic signed [18:0] v;
    pp = p * pgain;
    mm = m * mgain;
    if (diff) begin
      v = (signed'({2'b00, pp[31:15]}) - signed'({2'b00, mm[31:15]})) >>> 1;
    end else begin
      v = signed'({2'b00, pp[31:15]});
    end
    v = v - signed'({{3{ofs[15]}}, ofs});
    if (diff) begin
      if (v > 19'sh07fff) begin
        correct = 16'h7fff;
      end else if (v < -19'sh08000) begin
        correct = 16'h8000;
      end else begin
        correct = v[15:0];
      end
    end else begin
      if (v > 19'sh0ffff) begin
        correct = 16'hffff;
      end else if (v < 19'sh00000) begin
        correct = 16'h0000;
      end else begin
        correct = v[15:0];
      end
    end
  endfunction

  // Seven trim values of widths 6,7,8,9,10,6,6 from one code
  function automatic logic [51:0] packTrim(input logic [5:0] c);
    packTrim = {c, c, c, 4'h0, c, 3'h0, c, 2'h0, c, 1'b0, c};
  endfunction

  // Last index of an averaged set
  function automatic logic [5:0] avgLast(input logic [1:0] sel);
    unique case (sel)
      2'b00: avgLast = 6'h03;
      2'b01: avgLast = 6'h07;
      2'b10: avgLast = 6'h0f;
      2'b11: avgLast = 6'h1f;
    endcase
  endfunction

  logic        accept;
  logic        wrEn;
  logic        wrCtrl;
  logic        wrCfg;
  logic        wrStat;
  logic        calReq;
  logic        swStart;
  logic        hwStart;
  logic        calFailNow;
  logic        calEnd;
  logic [15:0] sample;
  logic [21:0] accNext;
  logic [21:0] avgOut;
  logic [2:0]  evt;
  logic [31:0] rd;

  assign accept  = (avs_read | avs_write) & s_q.ack;
  assign wrEn    = avs_write & s_q.ack & avs_byteenable[0];
  assign wrCtrl  = wrEn & (avs_address == REG_CTRL);
  assign wrCfg   = wrEn & (avs_address == REG_CFG);
  assign wrStat  = wrEn & (avs_address == REG_STAT);
  assign calReq  = wrCtrl & avs_writedata[CTRL_CAL_BIT] & (s_q.st != ST_CAL);
  assign swStart = wrCfg & avs_writedata[CFG_START_BIT]
                 & ~avs_writedata[CFG_TRG_BIT];
  assign hwStart = s_q.trgSel & s_q.hw2 & ~s_q.hw3;
  // Any write to the control, offset, gain or claim registers while trimming spoils the result
  assign calFailNow = (s_q.st == ST_CAL) & (s_q.trgSel | s_q.stop2
                    | (wrEn & (avs_address <= REG_CLAIM_2)));
  assign calEnd  = (s_q.st == ST_CAL)
                 & (s_q.calCnt == CAL_CNT_W'(CAL_CYCLES - 1));
  assign sample  = correct(rawPlus, rawMinus, s_q.pg, s_q.mg, s_q.ofs,
                           s_q.diffMode);
  assign accNext = s_q.acc + (s_q.diffMode ? {{6{sample[15]}}, sample}
                                           : {6'h00, sample});
  // Shift widened: a two-bit sum would wrap for sets of sixteen and thirty-two
  assign avgOut  = signed'(accNext) >>> ({1'b0, s_q.mean_count_select} + 3'd2);

  always_comb begin
    rd = 32'h0;
    unique case (avs_address)
      REG_CTRL:    rd[7:0] = {s_q.st == ST_CAL, s_q.selftrim_fail_flag, 2'b00, s_q.continuous_run_enable,
                              s_q.mean_enable, s_q.mean_count_select};
      REG_OFS_HI:  rd[7:0] = s_q.ofs[15:8];
      REG_OFS_LO:  rd[7:0] = s_q.ofs[7:0];
      REG_PG_HI:   rd[7:0] = s_q.pg[15:8];
      REG_PG_LO:   rd[7:0] = s_q.pg[7:0];
      REG_MG_HI:   rd[7:0] = s_q.mg[15:8];
      REG_MG_LO:   rd[7:0] = s_q.mg[7:0];
      REG_CLAIM_1: rd[7:0] = s_q.claim[7:0];
      REG_CLAIM_2: rd[7:0] = s_q.claim[15:8];
      REG_CFG:     rd[7:0] = {6'h00, s_q.diffMode, s_q.trgSel};
      REG_STAT:    rd[2:0] = s_q.irqStat;
      REG_MASK:    rd[2:0] = s_q.irqMask;
      REG_RESULT:  rd[15:0] = s_q.result;
      REG_TRIMP_L: rd[29:0] = s_q.trimP[29:0];
      REG_TRIMP_H: rd[21:0] = s_q.trimP[51:30];
      REG_TRIMM_L: rd[29:0] = s_q.trimM[29:0];
      REG_TRIMM_H: rd[21:0] = s_q.trimM[51:30];
      default:     rd = 32'h0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    evt = 3'b000;
    s_d.convStart = 1'b0;
    s_d.convAbort = 1'b0;
    // One wait state: read data is captured before waitrequest drops
    s_d.ack   = (avs_read | avs_write) & ~s_q.ack;
    s_d.rdata = (avs_read & ~s_q.ack) ? rd : s_q.rdata;
    s_d.hw1   = hwTrigger;
    s_d.hw2   = s_q.hw1;
    s_d.hw3   = s_q.hw2;
    s_d.stop1 = stopMode;
    s_d.stop2 = s_q.stop1;
    s_d.pad1  = padIn;
    s_d.pad2  = s_q.pad1;
    s_d.portIn  = s_q.pad2 & ~s_q.claim;
    s_d.padOe   = portOe & ~s_q.claim;
    s_d.padPull = portPullEn & ~s_q.claim;
    if (wrEn) begin
      unique case (avs_address)
        REG_CTRL: begin
          s_d.continuous_run_enable = avs_writedata[CTRL_CONTINUOUS_RUN_ENABLE_BIT];
          s_d.mean_enable = avs_writedata[CTRL_MEAN_ENABLE_BIT];
          s_d.mean_count_select = avs_writedata[CTRL_MEAN_COUNT_SELECT_LSB +: 2];
        end
        REG_OFS_HI:  s_d.ofs[15:8]    = avs_writedata[7:0];
        REG_OFS_LO:  s_d.ofs[7:0]     = avs_writedata[7:0];
        REG_PG_HI:   s_d.pg[15:8]     = avs_writedata[7:0];
        REG_PG_LO:   s_d.pg[7:0]      = avs_writedata[7:0];
        REG_MG_HI:   s_d.mg[15:8]     = avs_writedata[7:0];
        REG_MG_LO:   s_d.mg[7:0]      = avs_writedata[7:0];
        REG_CLAIM_1: s_d.claim[7:0]   = avs_writedata[7:0];
        REG_CLAIM_2: s_d.claim[15:8]  = avs_writedata[7:0];
        REG_CFG: begin
          s_d.trgSel   = avs_writedata[CFG_TRG_BIT];
          s_d.diffMode = avs_writedata[CFG_DIFF_BIT];
        end
        REG_MASK:    s_d.irqMask = avs_writedata[2:0];
        default:     s_d.irqMask = s_q.irqMask;
      endcase
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (swStart | hwStart) begin
          s_d.st = ST_CONV;
          s_d.convStart = 1'b1;
          s_d.acc = 22'h0;
          s_d.avgCnt = 6'h00;
        end
      end
      ST_CONV: begin
        if (convDone) begin
          if (!s_q.mean_enable) begin
            s_d.result = sample;
            evt[IRQ_READY] = 1'b1;
            s_d.convStart = s_q.continuous_run_enable;
            s_d.st = s_q.continuous_run_enable ? ST_CONV : ST_IDLE;
          end else if (s_q.avgCnt == avgLast(s_q.mean_count_select)) begin
            s_d.result = avgOut[15:0];
            evt[IRQ_READY] = 1'b1;
            s_d.acc = 22'h0;
            s_d.avgCnt = 6'h00;
            s_d.convStart = s_q.continuous_run_enable;
            s_d.st = s_q.continuous_run_enable ? ST_CONV : ST_IDLE;
          end else begin
            s_d.acc = accNext;
            s_d.avgCnt = s_q.avgCnt + 6'h01;
            s_d.convStart = 1'b1;
          end
        end
      end
      ST_CAL: begin
        s_d.calCnt = s_q.calCnt + CAL_CNT_W'(1);
        // A failure ends the sequence at once; trims keep old values
        if (calFailNow) begin
          s_d.st = ST_IDLE;
          evt[IRQ_CALFAIL] = 1'b1;
        end else if (calEnd) begin
          s_d.st = ST_IDLE;
          s_d.trimP = packTrim(calCodePlus);
          s_d.trimM = packTrim(calCodeMinus);
          evt[IRQ_CALDONE] = 1'b1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (calReq) begin
      s_d.convAbort = (s_q.st == ST_CONV);
      s_d.convStart = 1'b0;
      s_d.st = ST_CAL;
      s_d.calCnt = '0;
    end
    // Set wins over a clear in the same cycle
    s_d.selftrim_fail_flag = (s_q.selftrim_fail_flag & ~(wrCtrl & avs_writedata[CTRL_SELFTRIM_FAIL_FLAG_BIT]))
             | evt[IRQ_CALFAIL];
    s_d.irqStat = (s_q.irqStat & ~(wrStat ? avs_writedata[2:0] : 3'b000))
                | evt;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_q       <= '0;
      s_q.pg    <= GAIN_RESET;
      s_q.mg    <= GAIN_RESET;
      s_q.ofs   <= OFS_RESET;
      s_q.claim <= CLAIM_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign convStart       = s_q.convStart;
  assign convAbort       = s_q.convAbort;
  assign calBusy         = (s_q.st == ST_CAL);
  assign irq             = |(s_q.irqStat & s_q.irqMask);
  assign padOe           = s_q.padOe;
  assign padPullEn       = s_q.padPull;
  assign portIn          = s_q.portIn;
  assign pinClaim        = s_q.claim;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_cal_aborts_conv: assert property (ce && calReq && s_q.st == ST_CONV
    |=> s_q.convAbort && s_q.st == ST_CAL) else $error("no abort");
  a_cal_bit_busy: assert property (ce && calReq
    |=> calBusy && !s_q.convStart) else $error("cal not busy");
  a_cal_ends_ok: assert property (ce && calEnd && !calFailNow && !calReq
    |=> !calBusy && s_q.irqStat[IRQ_CALDONE]
        && s_q.trimP == packTrim($past(calCodePlus))
        && s_q.trimM == packTrim($past(calCodeMinus)))
    else $error("bad cal end");
  a_fail_on_trig: assert property (ce && calBusy && s_q.trgSel
    |=> s_q.selftrim_fail_flag && !calBusy) else $error("cal fail missed");
  a_selftrim_fail_flag_sticky: assert property (s_q.selftrim_fail_flag
    && !(ce && wrCtrl && avs_writedata[CTRL_SELFTRIM_FAIL_FLAG_BIT])
    |=> s_q.selftrim_fail_flag) else $error("selftrim_fail_flag lost");
  a_single_stops: assert property (ce && s_q.st == ST_CONV && convDone
    && !s_q.mean_enable && !s_q.continuous_run_enable && !calReq
    |=> s_q.st == ST_IDLE && !s_q.convStart) else $error("no stop");
  a_continuous_run: assert property (ce && s_q.st == ST_CONV && convDone
    && !s_q.mean_enable && s_q.continuous_run_enable && !calReq
    |=> s_q.convStart) else $error("no restart");
  a_avg_set_len: assert property (ce && s_q.st == ST_CONV && s_q.mean_enable
    && convDone && s_q.avgCnt != avgLast(s_q.mean_count_select) && !calReq
    |=> s_q.avgCnt == $past(s_q.avgCnt) + 6'h01
        && !s_q.irqStat[IRQ_READY] == !$past(s_q.irqStat[IRQ_READY]))
    else $error("avg count");
  a_claim_isolate: assert property (ce
    |=> (s_q.padOe & $past(s_q.claim)) == 16'h0
        && (s_q.padPull & $past(s_q.claim)) == 16'h0)
    else $error("claimed pin driven");

  c_cal_ok: cover property (ce && calEnd && !calFailNow);
  c_cal_fail: cover property (ce && calFailNow);
  c_avg_done: cover property (ce && s_q.mean_enable && convDone
    && s_q.avgCnt == avgLast(s_q.mean_count_select));
  c_abort: cover property (s_q.convAbort);

endmodule

// *** sim/tb.sv ***
// Self-checking bench for the calibration and averaging control block
`timescale 1ns/100ps
module tb;
  import adcc_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'h1;
  logic [31:0] rdata;
  logic        waitReq;
  logic        convDone = 1'b0;
  logic [15:0] rawPlus = 16'h0;
  logic [15:0] rawMinus = 16'h0;
  logic [5:0]  codeP = 6'h05;
  logic [5:0]  codeM = 6'h0a;
  logic        stopMode = 1'b0;
  logic        convStart;
  logic        convAbort;
  logic        calBusy;
  logic        irq;
  logic [15:0] padIn = 16'hffff;
  logic [15:0] padOe;
  logic [15:0] padPull;
  logic [15:0] portIn;
  logic [15:0] pinClaim;
  logic [31:0] d;
  int          err_total = 0;
  int          cmp_count = 0;
  int          startCnt = 0;
  int          abortCnt = 0;

  adcc_calib_avg adcc_calib_avg_i (
    .mclk(mclk), .reset_n(reset_n), .ce(1'b1),
    .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .convDone(convDone), .rawPlus(rawPlus),
    .rawMinus(rawMinus), .calCodePlus(codeP), .calCodeMinus(codeM),
    .hwTrigger(1'b0), .stopMode(stopMode), .convStart(convStart),
    .convAbort(convAbort), .calBusy(calBusy), .irq(irq),
    .portOe(16'hffff), .portPullEn(16'hffff), .padIn(padIn),
    .padOe(padOe), .padPullEn(padPull), .portIn(portIn),
    .pinClaim(pinClaim)
  );

  always #2.5 mclk = ~mclk;
  // Pulse counters so one-cycle outputs are never missed
  always @(posedge mclk) begin
    if (convStart === 1'b1) startCnt <= startCnt + 1;
    if (convAbort === 1'b1) abortCnt <= abortCnt + 1;
  end

  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tmo(input string nm);
    err_total++;
    $display("[ERR] %s expected done seen timeout", nm);
    finish_test();
  endtask

  // Held until waitrequest is sampled low; one idle edge after release
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] v, input logic [3:0] b = 4'h1);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h0, v};
    be <= b;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    @(posedge mclk);
    while (waitReq !== 1'b0) begin
      if (++n > 20) tmo("waitrequest");
      @(posedge mclk);
    end
    d = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic waitIdle(input int lim, output int n);
    n = 0;
    while (calBusy !== 1'b0) begin
      if (++n > lim) tmo("calBusy");
      @(posedge mclk);
    end
  endtask

  // Answers one start pulse with one finished conversion
  task automatic feed(input logic [15:0] v);
    int n;
    n = 0;
    while (convStart !== 1'b1) begin
      if (++n > 50) tmo("convStart");
      @(posedge mclk);
    end
    rawPlus <= v;
    convDone <= 1'b1;
    @(posedge mclk);
    convDone <= 1'b0;
  endtask

  task automatic conv(input logic [15:0] v, input logic [7:0] c = 8'h04);
    bus(1, REG_CFG, c);
    feed(v);
    bus(0, REG_RESULT, 8'h00);
  endtask

  function automatic logic [31:0] trimL(input logic [5:0] c);
    return {2'b0, {3'b0, c} << 3, {2'b0, c} << 2, {1'b0, c} << 1, c};
  endfunction

  function automatic logic [31:0] trimH(input logic [5:0] c);
    return {10'h0, c, c, {4'b0, c} << 4};
  endfunction

  task automatic t_reset();
    bus(0, REG_PG_HI, 8'h00);
    chk("plusGainHi", d, 32'h80);
    bus(0, REG_MG_HI, 8'h00);
    chk("minusGainHi", d, 32'h80);
    bus(1, REG_OFS_LO, 8'hff, 4'h0);
    bus(0, REG_OFS_LO, 8'h00);
    chk("ofsNoLane", d, 32'h0);
    bus(1, 5'h11, 8'hff);
    bus(0, 5'h11, 8'h00);
    chk("unmapped", d, 32'h0);
  endtask

  task automatic t_claim();
    bus(1, REG_CLAIM_1, 8'ha5);
    bus(1, REG_CLAIM_2, 8'h3c);
    // Pad input passes a two-stage synchroniser
    repeat (4) @(posedge mclk);
    chk("pinClaim", pinClaim, 32'h3ca5);
    chk("padOe", padOe, 32'hc35a);
    chk("padPull", padPull, 32'hc35a);
    chk("portIn", portIn, 32'hc35a);
    bus(0, REG_CLAIM_2, 8'h00);
    chk("claimHi", d, 32'h3c);
  endtask

  task automatic t_conv();
    int s0;
    s0 = startCnt;
    bus(1, REG_MG_HI, 8'h00);
    bus(1, REG_OFS_LO, 8'h10);
    conv(16'h1234);
    chk("ofsSub", d, 32'h1224);
    repeat (10) @(posedge mclk);
    chk("oneShot", startCnt - s0, 1);
    bus(1, REG_MASK, 8'h00);
    chk("irqMasked", irq, 1'b0);
    bus(1, REG_MASK, 8'h01);
    chk("irqOn", irq, 1'b1);
    bus(1, REG_STAT, 8'h01);
    chk("irqClr", irq, 1'b0);
    bus(1, REG_OFS_HI, 8'h01);
    bus(1, REG_OFS_LO, 8'h00);
    conv(16'h0050);
    chk("clampLow", d, 32'h0);
    bus(1, REG_PG_HI, 8'h40);
    conv(16'h2000);
    chk("gainHalf", d, 32'h0f00);
    bus(1, REG_PG_HI, 8'hff);
    bus(1, REG_PG_LO, 8'hff);
    conv(16'hffff);
    chk("clampHigh", d, 32'hffff);
    bus(1, REG_PG_HI, 8'h80);
    bus(1, REG_PG_LO, 8'h00);
    bus(1, REG_OFS_HI, 8'h00);
    // Differential: minus side scaled by its own gain, halved difference
    bus(1, REG_MG_HI, 8'h40);
    rawMinus <= 16'h1000;
    conv(16'h3000, 8'h06);
    chk("diffMinusGain", d, 32'h1400);
  endtask

  task automatic t_avg();
    int n;
    int s0;
    for (int k = 0; k < 4; k++) begin
      n = 4 << k;
      s0 = startCnt;
      bus(1, REG_CTRL, 8'h04 | 8'(k));
      bus(1, REG_CFG, 8'h04);
      for (int i = 0; i < n; i++) feed(16'h1000 + 16'(3 * i));
      bus(0, REG_RESULT, 8'h00);
      chk("mean", d, 32'h1000 + (3 * (n - 1)) / 2);
      repeat (10) @(posedge mclk);
      chk("setStarts", startCnt - s0, n);
    end
  endtask

  task automatic t_calok();
    int n;
    int s0;
    bus(1, REG_CTRL, 8'h08);
    bus(1, REG_CFG, 8'h04);
    feed(16'h0100);
    feed(16'h0200);
    s0 = abortCnt;
    bus(1, REG_CTRL, 8'h80);
    @(posedge mclk);
    chk("abort", abortCnt - s0, 1);
    bus(0, REG_CTRL, 8'h00);
    chk("calRuns", d[7:6], 2'b10);
    waitIdle(1200, n);
    chk("calLength", n > 980 && n < 1001, 1'b1);
    bus(0, REG_CTRL, 8'h00);
    chk("calEnds", d[7:6], 2'b00);
    bus(0, REG_TRIMP_L, 8'h00);
    chk("trimPlusLo", d, trimL(codeP));
    bus(0, REG_TRIMP_H, 8'h00);
    chk("trimPlusHi", d, trimH(codeP));
    bus(0, REG_TRIMM_L, 8'h00);
    chk("trimMinusLo", d, trimL(codeM));
    bus(0, REG_TRIMM_H, 8'h00);
    chk("trimMinusHi", d, trimH(codeM));
  endtask

  // Causes in turn: register write, stop entry, hardware trigger select
  task automatic t_calfail();
    int n;
    codeP <= 6'h11;
    for (int k = 0; k < 3; k++) begin
      if (k == 2) bus(1, REG_CFG, 8'h01);
      bus(1, REG_CTRL, 8'h80);
      if (k == 0) bus(1, REG_OFS_HI, 8'h00);
      if (k == 1) stopMode <= 1'b1;
      waitIdle(20, n);
      stopMode <= 1'b0;
      bus(0, REG_CTRL, 8'h00);
      chk("failSet", d[6], 1'b1);
      bus(1, REG_CTRL, 8'h00);
      bus(0, REG_CTRL, 8'h00);
      chk("failKept", d[6], 1'b1);
      bus(1, REG_CTRL, 8'h40);
      bus(0, REG_CTRL, 8'h00);
      chk("failClr", d[6], 1'b0);
      if (k == 2) bus(1, REG_CFG, 8'h00);
    end
    bus(0, REG_TRIMP_L, 8'h00);
    chk("trimKept", d, trimL(6'h05));
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_claim();
    t_conv();
    t_avg();
    t_calok();
    t_calfail();
    finish_test();
  end

  initial begin
    #200000;
    tmo("run");
  end
endmodule
